// File: rtl/rim_pkg.sv
package rim_pkg;
   // ******************************
   // clock and timing
   // ******************************
   localparam real CLK_HZ          = 100.0e6;
   localparam int  CNT_W           = 34;
   localparam real HOLD_MIN_S      = 0.15;
   localparam real HOLD_MAX_S      = 4.0;
   localparam real GAP_MAX_S       = 4.0;
   localparam real OVR_MAX_MIN     = 2.0;
   localparam real OVR_SEQ_MAX_S   = 5.0;
   localparam real FLASH_HALF_S    = 0.5;
   localparam logic [CNT_W-1:0] HOLD_MIN_CYC    = CNT_W'($ceil(HOLD_MIN_S * CLK_HZ));
   localparam logic [CNT_W-1:0] HOLD_MAX_CYC    = CNT_W'($floor(HOLD_MAX_S * CLK_HZ));
   localparam logic [CNT_W-1:0] GAP_MAX_CYC     = CNT_W'($floor(GAP_MAX_S * CLK_HZ));
   localparam logic [CNT_W-1:0] OVR_MAX_CYC     = CNT_W'($floor(OVR_MAX_MIN * 60.0 * CLK_HZ));
   localparam logic [CNT_W-1:0] OVR_SEQ_MAX_CYC = CNT_W'($floor(OVR_SEQ_MAX_S * CLK_HZ));
   localparam logic [CNT_W-1:0] FLASH_HALF_CYC  = CNT_W'($floor(FLASH_HALF_S * CLK_HZ));

   // ******************************
   // sequencer states
   // ******************************
   typedef enum logic [2:0] {
      ST_LOCKED,
      ST_HOLD,
      ST_ON,
      ST_MERR,
      ST_MHOLD1,
      ST_MGAP,
      ST_MOVR
   } rim_state_t;
endpackage : rim_pkg

// File: rtl/rim_pin_sync.sv
`timescale 1ns/1ps
module rim_pin_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // pins and filtered levels
   input  wire logic [WIDTH-1:0] pinIn,
   output      logic [WIDTH-1:0] levelOut
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } rim_sync_t;

   rim_sync_t st_ff;
   rim_sync_t nxt_st;

   // ******************************
   // three stages, change taken when stages two and three agree
   // ******************************
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = pinIn;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.lvl[i] = st_ff.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign levelOut = st_ff.lvl;
endmodule : rim_pin_sync

// File: rtl/rim_restart_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - trip, power loss, muting fault lock restart
// - red lit while locked, yellow too with clear field
// - yellow lit only with clear field
// - press, release after 0.15-4 s unlocks
// - muting restart only during muting error
// - held second press overrides up to 2 min
// - sequenced two-sensor muting limits override 5 s
// - release ends override early, before the limit
// - release: valid muting resumes, else outputs off
// - control signal restarts like the button
module rim_restart_ctrl
   import rim_pkg::*;
#(
   parameter logic [rim_pkg::CNT_W-1:0] HOLD_MIN    = rim_pkg::HOLD_MIN_CYC,
   parameter logic [rim_pkg::CNT_W-1:0] HOLD_MAX    = rim_pkg::HOLD_MAX_CYC,
   parameter logic [rim_pkg::CNT_W-1:0] GAP_MAX     = rim_pkg::GAP_MAX_CYC,
   parameter logic [rim_pkg::CNT_W-1:0] OVR_MAX     = rim_pkg::OVR_MAX_CYC,
   parameter logic [rim_pkg::CNT_W-1:0] OVR_SEQ_MAX = rim_pkg::OVR_SEQ_MAX_CYC,
   parameter logic [rim_pkg::CNT_W-1:0] FLASH_HALF  = rim_pkg::FLASH_HALF_CYC
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // restart sources (pins)
   input  wire logic restartBtn,
   input  wire logic plcRestart,
   // sensing and configuration status
   input  wire logic fieldClear,
   input  wire logic mutingValid,
   input  wire logic mutingFault,
   input  wire logic seqTwoSensor,
   // indicators
   output      logic redLed,
   output      logic yellowLed,
   output      logic greenLed,
   output      logic mutingLed,
   // safety switching outputs
   output      logic safety_switching_outputs,
   output      logic restartLocked
);
   import rim_pkg::*;

   typedef struct packed {
      rim_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] flashCnt;
      logic             flash;
      logic             btnPrev;
      logic             red;
      logic             yellow;
      logic             green;
      logic             mute;
      logic             safe;
      logic             locked;
   } rim_ctrl_t;

   rim_ctrl_t  st_ff;
   rim_ctrl_t  nxt_st;
   logic [1:0] srcLvl;
   logic       btn;
   logic       press;
   logic       release_;
   logic       holdOk;
   logic [CNT_W-1:0] ovrLimit;

   // a window's first cycle counts as one, so a count equals its length
   localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // ******************************
   // restart sources
   // ******************************
   rim_pin_sync #(
      .WIDTH (2)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .pinIn    ({plcRestart, restartBtn}),
      .levelOut (srcLvl)
   );

   // button and control signal act alike once synchronised
   assign btn      = srcLvl[0] | srcLvl[1];

   // ******************************
   // edge events
   // ******************************
   // btnPrev resets low like the idle pins, so reset makes no false press
   assign press    = btn & ~st_ff.btnPrev;
   assign release_ = ~btn & st_ff.btnPrev;

   // ******************************
   // windows and limits
   // ******************************
   // hold window, both ends inclusive
   assign holdOk   = (st_ff.cnt >= HOLD_MIN) && (st_ff.cnt <= HOLD_MAX);
   assign ovrLimit = seqTwoSensor ? OVR_SEQ_MAX : OVR_MAX;

   // ******************************
   // sequencer
   // ******************************
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.btnPrev = btn;
      // counter saturates at all ones, well past the longest window
      if (st_ff.cnt != {CNT_W{1'b1}}) begin
         nxt_st.cnt = st_ff.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      case (st_ff.state)
         ST_LOCKED: begin
            if (press) begin
               // the press edge counts as the first held cycle
               nxt_st.state = ST_HOLD;
               nxt_st.cnt   = ONE;
            end
         end
         ST_HOLD: begin
            if (release_) begin
               nxt_st.state = holdOk ? ST_ON : ST_LOCKED;
            end
         end
         ST_ON: begin
            if (mutingFault) begin
               nxt_st.state = ST_MERR;
            end else if (!fieldClear && !mutingValid) begin
               nxt_st.state = ST_LOCKED;
            end
         end
         ST_MERR: begin
            if (press) begin
               nxt_st.state = ST_MHOLD1;
               nxt_st.cnt   = ONE;
            end
         end
         ST_MHOLD1: begin
            if (release_) begin
               nxt_st.state = holdOk ? ST_MGAP : ST_MERR;
               nxt_st.cnt   = ONE;
            end
         end
         ST_MGAP: begin
            if (press) begin
               nxt_st.state = ST_MOVR;
               nxt_st.cnt   = ONE;
            end else if (st_ff.cnt >= GAP_MAX) begin
               // gap too long: back to muting error
               nxt_st.state = ST_MERR;
            end
         end
         ST_MOVR: begin
            // limit ends the override even with the input still held
            if (st_ff.cnt >= ovrLimit) begin
               nxt_st.state = ST_MERR;
            end else if (!btn) begin
               nxt_st.state = mutingValid ? ST_ON : ST_MERR;
            end
         end
         default: begin
            nxt_st.state = ST_LOCKED;
         end
      endcase

      // ******************************
      // muting error flash timebase
      // ******************************
      // each phase lasts FLASH_HALF cycles
      if (st_ff.flashCnt >= FLASH_HALF - ONE) begin
         nxt_st.flashCnt = '0;
         nxt_st.flash    = ~st_ff.flash;
      end else begin
         nxt_st.flashCnt = st_ff.flashCnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end

      // ******************************
      // indicators and outputs follow the next state
      // ******************************
      nxt_st.locked = (nxt_st.state != ST_ON) && (nxt_st.state != ST_MOVR);
      nxt_st.red    = nxt_st.locked;
      nxt_st.yellow = nxt_st.locked && fieldClear;
      nxt_st.green  = !nxt_st.locked;
      nxt_st.safe   = !nxt_st.locked;
      // muting indicator: flashing error, steady override, muting status in ON
      case (nxt_st.state)
         ST_MERR, ST_MHOLD1, ST_MGAP: begin
            nxt_st.mute = nxt_st.flash;
         end
         ST_MOVR: begin
            nxt_st.mute = 1'b1;
         end
         ST_ON: begin
            nxt_st.mute = mutingValid;
         end
         default: begin
            nxt_st.mute = 1'b0;
         end
      endcase
   end

   // ******************************
   // state register
   // ******************************
   // reset models a supply loss: locked, outputs off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff        <= '0;
         st_ff.state  <= ST_LOCKED;
         st_ff.locked <= 1'b1;
         st_ff.red    <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ******************************
   // outputs, each straight from a flip-flop
   // ******************************
   assign redLed                   = st_ff.red;
   assign yellowLed                = st_ff.yellow;
   assign greenLed                 = st_ff.green;
   assign mutingLed                = st_ff.mute;
   assign safety_switching_outputs = st_ff.safe;
   assign restartLocked            = st_ff.locked;
endmodule : rim_restart_ctrl

// File: sim/rim_restart_ctrl_monitor.sv
`timescale 1ns/1ps
module rim_restart_ctrl_monitor
   import rim_pkg::*;
#(
   parameter logic [rim_pkg::CNT_W-1:0] OVR_MAX     = rim_pkg::OVR_MAX_CYC,
   parameter logic [rim_pkg::CNT_W-1:0] OVR_SEQ_MAX = rim_pkg::OVR_SEQ_MAX_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // inputs
   input wire logic restartBtn,
   input wire logic plcRestart,
   input wire logic fieldClear,
   input wire logic mutingValid,
   input wire logic seqTwoSensor,
   // outputs
   input wire logic redLed,
   input wire logic yellowLed,
   input wire logic greenLed,
   input wire logic mutingLed,
   input wire logic safety_switching_outputs,
   input wire logic restartLocked
);
   // override cycles without a valid muting condition
   logic [CNT_W-1:0] ovrCnt_ff;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         ovrCnt_ff <= '0;
      else if (safety_switching_outputs && mutingLed && !mutingValid)
         ovrCnt_ff <= ovrCnt_ff + 1'b1;
      else
         ovrCnt_ff <= '0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_lock_outs_off: assert property (restartLocked |-> !safety_switching_outputs)
      else $error("outputs on while locked");
   a_lock_red_on: assert property (restartLocked |-> redLed)
      else $error("red off while locked");
   a_yellow_field: assert property (yellowLed |-> restartLocked && $past(fieldClear))
      else $error("yellow lit without clear field");
   a_green_state: assert property (greenLed == safety_switching_outputs && greenLed != restartLocked)
      else $error("green, outputs and lock disagree");
   a_trip_locks: assert property (!restartLocked && !mutingLed && !fieldClear && !mutingValid
      |-> ##[1:2] restartLocked)
      else $error("no lock after trip");
   a_lock_needs_input: assert property ((restartLocked && !restartBtn && !plcRestart) [*8]
      |=> restartLocked)
      else $error("unlocked without restart input");
   a_ovr_limit: assert property (!seqTwoSensor |-> ovrCnt_ff <= OVR_MAX)
      else $error("override too long");
   a_seq_limit: assert property (seqTwoSensor |-> ovrCnt_ff <= OVR_SEQ_MAX)
      else $error("sequenced override too long");
endmodule : rim_restart_ctrl_monitor

bind rim_restart_ctrl rim_restart_ctrl_monitor #(.OVR_MAX(OVR_MAX), .OVR_SEQ_MAX(OVR_SEQ_MAX)) u_mon (
   .sys_clk, .rst, .restartBtn, .plcRestart, .fieldClear, .mutingValid, .seqTwoSensor, .redLed,
   .yellowLed, .greenLed, .mutingLed, .safety_switching_outputs, .restartLocked);

// File: sim/rim_btn_model.sv
`timescale 1ns/1ps
module rim_btn_model (
   // clock
   input  wire logic sys_clk,
   // restart pin
   output      logic pin
);
   initial pin = 1'b0;
   // n > 0: hold n cycles then release; 0 keeps it held; < 0 releases
   task automatic press(input int n);
      pin = (n >= 0);
      if (n > 0) begin
         repeat (n) @(negedge sys_clk);
         pin = 1'b0;
      end
   endtask : press
endmodule : rim_btn_model

// File: sim/rim_restart_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module rim_restart_ctrl_tb;
   import rim_pkg::*;
   localparam int HMIN = 5, HMAX = 20, OMAX = 60, OSEQ = 30;
   logic sys_clk = 1'b0, rst = 1'b1, fieldClear = 1'b1, mutingValid = 1'b0;
   logic mutingFault = 1'b0, seqTwoSensor = 1'b0, m;
   logic restartBtn, plcRestart, redLed, yellowLed, greenLed, mutingLed, safeOut, locked;
   int   error_cnt = 0, compares = 0, cycles = 0;
   always #5 sys_clk = ~sys_clk;
   rim_btn_model btn (.sys_clk(sys_clk), .pin(restartBtn));
   rim_btn_model plc (.sys_clk(sys_clk), .pin(plcRestart));
   rim_restart_ctrl #(.HOLD_MIN(CNT_W'(HMIN)), .HOLD_MAX(CNT_W'(HMAX)), .GAP_MAX(CNT_W'(20)),
      .OVR_MAX(CNT_W'(OMAX)), .OVR_SEQ_MAX(CNT_W'(OSEQ)), .FLASH_HALF(CNT_W'(4))) dut (
      .sys_clk, .rst, .restartBtn, .plcRestart, .fieldClear, .mutingValid, .mutingFault,
      .seqTwoSensor, .redLed, .yellowLed, .greenLed, .mutingLed,
      .safety_switching_outputs(safeOut), .restartLocked(locked));
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task automatic chk_state(input logic s, input logic l);
      `CHK(safeOut, s)
      `CHK(greenLed, s)
      `CHK(locked, l)
      `CHK(redLed, l)
   endtask : chk_state
   // first press and release, short gap, second press held h cycles
   task automatic mrest(input int h);
      btn.press(10);
      cyc(5);
      btn.press(h);
   endtask : mrest
   task automatic print_verdict();
      $display("compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      cyc(2);
      rst = 1'b0;
      cyc(2);
      chk_state(1'b0, 1'b1);
      `CHK(yellowLed, 1'b1)
      fieldClear = 1'b0;
      cyc(2);
      `CHK(yellowLed, 1'b0)
      fieldClear = 1'b1;
      for (int i = 0; i < 2; i++) begin
         btn.press(i ? HMAX + 1 : HMIN - 1);
         cyc(8);
         chk_state(1'b0, 1'b1);
      end
      $display("test locked done");
      for (int i = 0; i < 2; i++) begin
         if (i == 0) plc.press(HMIN);
         else btn.press(HMAX);
         cyc(8);
         chk_state(1'b1, 1'b0);
         fieldClear = 1'b0;
         cyc(3);
         chk_state(1'b0, 1'b1);
         fieldClear = 1'b1;
      end
      $display("test unlock done");
      btn.press(10);
      cyc(8);
      mutingFault = 1'b1;
      cyc(3);
      mutingFault = 1'b0;
      chk_state(1'b0, 1'b1);
      m = mutingLed;
      cyc(4);
      `CHK(mutingLed, ~m)
      for (int s = 0; s < 2; s++) begin
         seqTwoSensor = 1'(s);
         mrest(0);
         cyc(15);
         chk_state(1'b1, 1'b0);
         `CHK(mutingLed, 1'b1)
         cyc((s ? OSEQ : OMAX) - 20);
         chk_state(1'b1, 1'b0);
         cyc(20);
         chk_state(1'b0, 1'b1);
         btn.press(-1);
         cyc(5);
      end
      $display("test override limit done");
      mrest(0);
      cyc(15);
      btn.press(-1);
      cyc(8);
      chk_state(1'b0, 1'b1);
      mutingValid = 1'b1;
      mrest(3);
      cyc(10);
      chk_state(1'b1, 1'b0);
      `CHK(mutingLed, 1'b1)
      $display("test muting release done");
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(2);
      chk_state(1'b0, 1'b1);
      `CHK(mutingLed, 1'b0)
      $display("test power loss done");
      print_verdict();
   end
endmodule : rim_restart_ctrl_tb
